/* File: shared/pfs_consts.svh */
// Operation
// - Direction register holds one bit per pin; 1 makes output, 0 makes input.
// - Direction bit acts only in general I/O or timer capture/compare function.
// - Direction register clears to 0000 only at power-on reset; otherwise retained.
// - Power-on reset loads upper select 3302 and lower select FF95; otherwise retained.
// - Upper select steers pins 15-8, lower select pins 7-0; both 16-bit read/write; here the lower select is only exported and pins 7-0 stay plain I/O.
// - Pin 15: 00 I/O, 01 interrupt input 3, 10 reserved, 11 DMA request 1.
// - Pin 14: 00 I/O, 01 interrupt input 2, 10 reserved, 11 DMA acknowledge 1.
// - Pin 13: 00 I/O, 01 interrupt input 1, 10 timer clock B, 11 DMA request 0.
// - Pin 12: 00 I/O, 01 interrupt input 0, 10 timer clock A, 11 DMA acknowledge 0.
// - Pin 11: 00 I/O, 01 upper bus parity, 10 timer1 capture/compare B, 11 reserved.
// - Pin 10: 00 I/O, 01 lower bus parity, 10 timer1 capture/compare A, 11 reserved.
// - Pin 9: 00 I/O, 01 address hold, 10 A/D trigger, 11 interrupt request out.
// - Upper select bit 1 always reads 1; software always writes 1.
// - Pin 8: bit 0 clear selects I/O, set selects bus request input.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define PFS_OFS_DIR      8'h00
`define PFS_OFS_UPPER    8'h04
`define PFS_OFS_LOWER    8'h08
`define PFS_RST_DIR      16'h0000
`define PFS_RST_UPPER    16'h3302
`define PFS_RST_LOWER    16'hFF95
`define PFS_UPPER_RSVD   16'h0002

// ----------------------------------------
// Mode tables, one nibble per pin 15..8
// ----------------------------------------
`define PFS_MODE_OK      32'hBBFF77F3
`define PFS_DIR_USED     32'h11115511
`define PFS_MD_GPIO      2'h0

// ----------------------------------------
// Bus answers and idle levels
// ----------------------------------------
`define PFS_RESP_OKAY    2'h0
`define PFS_RESP_SLVERR  2'h2
`define PFS_IDLE_REQ     1'h1
`define PFS_IDLE_DATA    1'h0

`endif

/* File: shared/pfs_pkg.sv */
package pfs_pkg;
    typedef enum logic {WR_IDLE, WR_RESP} pfs_wr_e;
    typedef enum logic {RD_IDLE, RD_RESP} pfs_rd_e;
    typedef enum logic [1:0] {REG_DIR, REG_UPPER, REG_LOWER, REG_NONE} pfs_reg_e;
endpackage : pfs_pkg

/* File: hw/pfs_sync2.sv */
module pfs_sync2 #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pfs_sync_s;

    pfs_sync_s s;
    pfs_sync_s n;

    if (WIDTH < 1) begin : g_chk
        $error("pfs_sync2: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_comb begin
        n.meta   = d;
        n.stable = s.meta;
        if (!aresetn) begin
            n = '0;
        end
    end

    always_ff @(posedge aclk) begin
        s <= n;
    end

    assign q = s.stable;
endmodule : pfs_sync2

/* File: hw/pfs_pin_mux.sv */
`include "pfs_consts.svh"

module pfs_pin_mux (
    // Selection
    input  wire logic [1:0] mode,
    input  wire logic       dir_bit,
    input  wire logic [3:0] mode_ok,
    input  wire logic [3:0] dir_used,
    // Function sources, indexed by mode code
    input  wire logic [3:0] func_out,
    input  wire logic [3:0] func_oe,
    // Resolved drive and one-hot effective mode
    output logic            pin_out,
    output logic            pin_oe,
    output logic [3:0]      sel
);
    logic [1:0] eff;

    always_comb begin
        // A reserved code drives no peripheral function
        eff = mode_ok[mode] ? mode : `PFS_MD_GPIO;
        sel = 4'h0;
        sel[eff] = 1'b1;
        pin_out = func_out[eff];
        pin_oe  = dir_used[eff] ? dir_bit : func_oe[eff];
    end
endmodule : pfs_pin_mux

/* File: hw/pfs_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`include "pfs_consts.svh"

module pfs_top #(
    parameter int ADDR_W = 8
) (
    // Clock and power-on reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Port pins
    input  wire logic [15:0]       pin_in,
    output logic      [15:0]       pin_out,
    output logic      [15:0]       pin_oe,
    // Port data path
    input  wire logic [15:0]       port_out_data,
    output logic      [15:0]       port_in_data,
    output logic      [15:0]       lower_pin_function_select,
    // Peripheral outputs routed onto pins
    input  wire logic              dma_acknowledge_out_0,
    input  wire logic              dma_acknowledge_out_1,
    input  wire logic              timer1_cc_a_out,
    input  wire logic              timer1_cc_b_out,
    input  wire logic              upper_bus_parity_out,
    input  wire logic              upper_bus_parity_oe,
    input  wire logic              lower_bus_parity_out,
    input  wire logic              lower_bus_parity_oe,
    input  wire logic              address_hold_out,
    input  wire logic              interrupt_request_out,
    // Pin levels routed to peripherals
    output logic                   ext_int_req_in_0,
    output logic                   ext_int_req_in_1,
    output logic                   ext_int_req_in_2,
    output logic                   ext_int_req_in_3,
    output logic                   dma_request_in_0,
    output logic                   dma_request_in_1,
    output logic                   timer_ext_clock_a,
    output logic                   timer_ext_clock_b,
    output logic                   timer1_cc_a_in,
    output logic                   timer1_cc_b_in,
    output logic                   upper_bus_parity_in,
    output logic                   lower_bus_parity_in,
    output logic                   adc_trigger_in,
    output logic                   bus_request_in
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0]       dir;
        logic [15:0]       upper;
        logic [15:0]       lower;
        pfs_pkg::pfs_wr_e  wst;
        pfs_pkg::pfs_rd_e  rd_st;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] waddr;
        logic [15:0]       wdata;
        logic [1:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [15:0]       pin_out;
        logic [15:0]       pin_oe;
        logic [15:0]       port_in;
        logic [3:0]        irq;
        logic [1:0]        dreq;
        logic [1:0]        tclk;
        logic [1:0]        cc_in;
        logic [1:0]        par_in;
        logic              adc_trig;
        logic              bus_req;
    } pfs_top_s;

    pfs_top_s          s;
    pfs_top_s          n;
    logic [15:0]       pin_sync;
    logic              wr_fire;
    pfs_pkg::pfs_reg_e wsel;
    pfs_pkg::pfs_reg_e rsel;
    logic [7:0]        mux_out;
    logic [7:0]        mux_oe;
    logic [3:0]        sel [8];
    logic [3:0]        fo  [8];
    logic [3:0]        foe [8];

    localparam logic [31:0] MODE_OK  = `PFS_MODE_OK;
    localparam logic [31:0] DIR_USED = `PFS_DIR_USED;

    if (ADDR_W < 4) begin : g_chk
        $error("pfs_top: ADDR_W must be at least 4");
    end

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic pfs_pkg::pfs_reg_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] idx;
        idx = a[ADDR_W-1:2];
        if (idx == (ADDR_W-2)'(`PFS_OFS_DIR >> 2)) begin
            return pfs_pkg::REG_DIR;
        end else if (idx == (ADDR_W-2)'(`PFS_OFS_UPPER >> 2)) begin
            return pfs_pkg::REG_UPPER;
        end else if (idx == (ADDR_W-2)'(`PFS_OFS_LOWER >> 2)) begin
            return pfs_pkg::REG_LOWER;
        end
        return pfs_pkg::REG_NONE;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
        return {strb[1] ? new_v[15:8] : old_v[15:8],
                strb[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : merge16

    // Pin 8 has a single mode bit; the others a two-bit field
    function automatic logic [1:0] mode_of(input logic [15:0] up, input int j);
        if (j == 0) begin
            return {1'b0, up[0]};
        end
        return up[2*j+1 -: 2];
    endfunction : mode_of

    // ----------------------------------------
    // Pin synchroniser and per-pin muxes
    // ----------------------------------------
    pfs_sync2 #(
        .WIDTH (16)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pin_in),
        .q       (pin_sync)
    );

    always_comb begin
        fo[7]  = {3'h0, port_out_data[15]};
        foe[7] = 4'h0;
        fo[6]  = {dma_acknowledge_out_1, 2'h0, port_out_data[14]};
        foe[6] = 4'h8;
        fo[5]  = {3'h0, port_out_data[13]};
        foe[5] = 4'h0;
        fo[4]  = {dma_acknowledge_out_0, 2'h0, port_out_data[12]};
        foe[4] = 4'h8;
        fo[3]  = {1'b0, timer1_cc_b_out, upper_bus_parity_out, port_out_data[11]};
        foe[3] = {2'h0, upper_bus_parity_oe, 1'b0};
        fo[2]  = {1'b0, timer1_cc_a_out, lower_bus_parity_out, port_out_data[10]};
        foe[2] = {2'h0, lower_bus_parity_oe, 1'b0};
        fo[1]  = {interrupt_request_out, 1'b0, address_hold_out, port_out_data[9]};
        foe[1] = 4'hA;
        fo[0]  = {3'h0, port_out_data[8]};
        foe[0] = 4'h0;
    end

    for (genvar j = 0; j < 8; j++) begin : g_pin
        pfs_pin_mux u_mux (
            .mode     (mode_of(s.upper, j)),
            .dir_bit  (s.dir[8+j]),
            .mode_ok  (MODE_OK[4*j+3 -: 4]),
            .dir_used (DIR_USED[4*j+3 -: 4]),
            .func_out (fo[j]),
            .func_oe  (foe[j]),
            .pin_out  (mux_out[j]),
            .pin_oe   (mux_oe[j]),
            .sel      (sel[j])
        );
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n       = s;
        wr_fire = s.aw_held && s.w_held && (s.wst == pfs_pkg::WR_IDLE);
        wsel    = reg_sel(s.waddr);
        rsel    = reg_sel(s_axi_araddr);

        // Address and data may arrive in either order
        if (s_axi_awvalid && s.awready) begin
            n.aw_held = 1'b1;
            n.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_held = 1'b1;
            n.wdata  = s_axi_wdata[15:0];
            n.wstrb  = s_axi_wstrb[1:0];
        end
        if (wr_fire) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.wst     = pfs_pkg::WR_RESP;
            n.bresp   = `PFS_RESP_OKAY;
            case (wsel)
                pfs_pkg::REG_DIR: begin
                    n.dir = merge16(s.dir, s.wdata, s.wstrb);
                end
                pfs_pkg::REG_UPPER: begin
                    n.upper = merge16(s.upper, s.wdata, s.wstrb) | `PFS_UPPER_RSVD;
                end
                pfs_pkg::REG_LOWER: begin
                    n.lower = merge16(s.lower, s.wdata, s.wstrb);
                end
                default: begin
                    n.bresp = `PFS_RESP_SLVERR;
                end
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.wst    = pfs_pkg::WR_IDLE;
        end
        n.awready = !n.aw_held && (n.wst == pfs_pkg::WR_IDLE);
        n.wready  = !n.w_held && (n.wst == pfs_pkg::WR_IDLE);

        if (s_axi_arvalid && s.arready) begin
            n.rd_st = pfs_pkg::RD_RESP;
            n.rvalid = 1'b1;
            n.rresp  = `PFS_RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            case (rsel)
                pfs_pkg::REG_DIR: begin
                    n.rdata[15:0] = s.dir;
                end
                pfs_pkg::REG_UPPER: begin
                    n.rdata[15:0] = s.upper | `PFS_UPPER_RSVD;
                end
                pfs_pkg::REG_LOWER: begin
                    n.rdata[15:0] = s.lower;
                end
                default: begin
                    n.rresp = `PFS_RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.rd_st  = pfs_pkg::RD_IDLE;
        end
        n.arready = (n.rd_st == pfs_pkg::RD_IDLE);

        // Lower half is plain port I/O; its select value is only exported
        n.pin_out = {mux_out, port_out_data[7:0]};
        n.pin_oe  = {mux_oe, s.dir[7:0]};
        n.port_in = pin_sync;

        // Deselected inputs sit at their idle level
        n.irq[3]    = sel[7][1] ? pin_sync[15] : `PFS_IDLE_REQ;
        n.dreq[1]   = sel[7][3] ? pin_sync[15] : `PFS_IDLE_REQ;
        n.irq[2]    = sel[6][1] ? pin_sync[14] : `PFS_IDLE_REQ;
        n.irq[1]    = sel[5][1] ? pin_sync[13] : `PFS_IDLE_REQ;
        n.tclk[1]   = sel[5][2] ? pin_sync[13] : `PFS_IDLE_DATA;
        n.dreq[0]   = sel[5][3] ? pin_sync[13] : `PFS_IDLE_REQ;
        n.irq[0]    = sel[4][1] ? pin_sync[12] : `PFS_IDLE_REQ;
        n.tclk[0]   = sel[4][2] ? pin_sync[12] : `PFS_IDLE_DATA;
        n.par_in[1] = sel[3][1] ? pin_sync[11] : `PFS_IDLE_DATA;
        n.cc_in[1]  = sel[3][2] ? pin_sync[11] : `PFS_IDLE_DATA;
        n.par_in[0] = sel[2][1] ? pin_sync[10] : `PFS_IDLE_DATA;
        n.cc_in[0]  = sel[2][2] ? pin_sync[10] : `PFS_IDLE_DATA;
        n.adc_trig  = sel[1][2] ? pin_sync[9]  : `PFS_IDLE_REQ;
        n.bus_req   = sel[0][1] ? pin_sync[8]  : `PFS_IDLE_REQ;

        // Only the power-on reset touches the select registers
        if (!aresetn) begin
            n         = '0;
            n.dir     = `PFS_RST_DIR;
            n.upper   = `PFS_RST_UPPER;
            n.lower   = `PFS_RST_LOWER;
            n.awready = 1'b1;
            n.wready  = 1'b1;
            n.arready = 1'b1;
            n.irq     = 4'hF;
            n.dreq    = 2'h3;
            n.adc_trig = 1'b1;
            n.bus_req  = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        s <= n;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready             = s.awready;
    assign s_axi_wready              = s.wready;
    assign s_axi_bvalid              = s.bvalid;
    assign s_axi_bresp               = s.bresp;
    assign s_axi_arready             = s.arready;
    assign s_axi_rvalid              = s.rvalid;
    assign s_axi_rdata               = s.rdata;
    assign s_axi_rresp               = s.rresp;
    assign pin_out                   = s.pin_out;
    assign pin_oe                    = s.pin_oe;
    assign port_in_data              = s.port_in;
    assign lower_pin_function_select = s.lower;
    assign ext_int_req_in_0          = s.irq[0];
    assign ext_int_req_in_1          = s.irq[1];
    assign ext_int_req_in_2          = s.irq[2];
    assign ext_int_req_in_3          = s.irq[3];
    assign dma_request_in_0          = s.dreq[0];
    assign dma_request_in_1          = s.dreq[1];
    assign timer_ext_clock_a         = s.tclk[0];
    assign timer_ext_clock_b         = s.tclk[1];
    assign timer1_cc_a_in            = s.cc_in[0];
    assign timer1_cc_b_in            = s.cc_in[1];
    assign upper_bus_parity_in       = s.par_in[1];
    assign lower_bus_parity_in       = s.par_in[0];
    assign adc_trigger_in            = s.adc_trig;
    assign bus_request_in            = s.bus_req;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_rst_values: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> s.dir == `PFS_RST_DIR && s.upper == `PFS_RST_UPPER
                            && s.lower == `PFS_RST_LOWER)
        else $error("select registers wrong after reset");
    a_dir_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wsel == pfs_pkg::REG_DIR && s.wstrb == 2'h3 |=> s.dir == $past(s.wdata))
        else $error("direction write lost");
    a_dir_retain: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_fire && wsel == pfs_pkg::REG_DIR) |=> $stable(s.dir))
        else $error("direction changed without a write");
    a_upper_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s.arready && rsel == pfs_pkg::REG_UPPER |=> s.rvalid && s.rdata[1])
        else $error("reserved upper bit read as zero");
    a_lower_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s.arready && rsel == pfs_pkg::REG_LOWER
        |=> s.rdata == {16'h0000, $past(s.lower)})
        else $error("lower select read mismatch");
    a_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s.awready && s_axi_wvalid && s.wready |-> ##2 s.bvalid)
        else $error("write response late");
    a_gpio_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[15:14] == 2'h0 |=> s.pin_oe[15] == $past(s.dir[15])
                                  && s.pin_out[15] == $past(port_out_data[15]))
        else $error("pin 15 general I/O drive wrong");
    a_int3_route: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[15:14] == 2'h1 |=> s.irq[3] == $past(pin_sync[15]) && !s.pin_oe[15])
        else $error("pin 15 interrupt routing wrong");
    a_ack1_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[13:12] == 2'h3 |=> s.pin_oe[14] && s.pin_out[14] == $past(dma_acknowledge_out_1))
        else $error("pin 14 acknowledge drive wrong");
    a_clock_b_in: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[11:10] == 2'h2 |=> s.tclk[1] == $past(pin_sync[13]) && !s.pin_oe[13])
        else $error("pin 13 timer clock wrong");
    a_ack0_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[9:8] == 2'h3 |=> s.pin_oe[12] && s.pin_out[12] == $past(dma_acknowledge_out_0))
        else $error("pin 12 acknowledge drive wrong");
    a_cc_b1_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[7:6] == 2'h2 |=> s.pin_oe[11] == $past(s.dir[11])
                                && s.pin_out[11] == $past(timer1_cc_b_out))
        else $error("pin 11 capture/compare drive wrong");
    a_parity_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[5:4] == 2'h1 |=> s.pin_oe[10] == $past(lower_bus_parity_oe))
        else $error("pin 10 parity enable wrong");
    a_int_out_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[3:2] == 2'h3 |=> s.pin_oe[9] && s.pin_out[9] == $past(interrupt_request_out))
        else $error("pin 9 interrupt output wrong");
    a_bus_req_route: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[0] |=> s.bus_req == $past(pin_sync[8]) && !s.pin_oe[8])
        else $error("pin 8 bus request wrong");
    a_rsvd_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
        s.upper[7:6] == 2'h3 |=> s.pin_oe[11] == $past(s.dir[11])
                                && s.cc_in[1] == `PFS_IDLE_DATA)
        else $error("reserved code not general I/O");
endmodule : pfs_top

/* File: test/port_a_pin_function_select_test.sv */
`include "pfs_consts.svh"

module port_a_pin_function_select_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] pin_in = 16'h0, port_out_data = 16'h0;
    logic [15:0] pin_out, pin_oe, port_in_data, lower_pin_function_select;
    logic        drv = 1'h0;
    wire  [13:0] per;
    int          error_cnt = 0;
    int          total_checks = 0;
    // Mode rows: upper select, direction, drive enable, driven level, inputs at pin 0 and 1
    logic [15:0] t_up [5] = '{16'h5557, 16'hAAAA, 16'hAAAA, 16'hFFFF, 16'h0002};
    logic [15:0] t_dr [5] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};
    logic [15:0] t_oe [5] = '{16'h0EFF, 16'hCDFF, 16'h0000, 16'h5EFF, 16'h0000};
    logic [15:0] t_po [5] = '{16'h0E00, 16'h0C00, 16'h0000, 16'h5200, 16'h0000};
    logic [13:0] t_lo [5] = '{14'h0302, 14'h0000, 14'h3F01, 14'h3C02, 14'h3F03};
    logic [13:0] t_hi [5] = '{14'h3F0F, 14'h0000, 14'h3FF3, 14'h3F03, 14'h3F03};

    always #12.5 aclk = ~aclk;

    pfs_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .port_out_data,
        .port_in_data, .lower_pin_function_select, .dma_acknowledge_out_0(drv),
        .dma_acknowledge_out_1(drv), .timer1_cc_a_out(drv), .timer1_cc_b_out(drv),
        .upper_bus_parity_out(drv), .upper_bus_parity_oe(drv), .lower_bus_parity_out(drv),
        .lower_bus_parity_oe(drv), .address_hold_out(drv), .interrupt_request_out(drv),
        .ext_int_req_in_3(per[13]), .ext_int_req_in_2(per[12]), .ext_int_req_in_1(per[11]),
        .ext_int_req_in_0(per[10]), .dma_request_in_1(per[9]), .dma_request_in_0(per[8]),
        .timer_ext_clock_a(per[7]), .timer_ext_clock_b(per[6]), .timer1_cc_a_in(per[5]),
        .timer1_cc_b_in(per[4]), .upper_bus_parity_in(per[3]), .lower_bus_parity_in(per[2]),
        .adc_trigger_in(per[1]), .bus_request_in(per[0]));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) done = 1'b1;
        end
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) done = 1'b1;
        end
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd

    // Pin inputs reach the outputs three edges later through the synchroniser; five leaves margin
    task automatic settle;
        repeat (5) @(posedge aclk);
    endtask : settle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(`PFS_OFS_DIR, 32'h0, `PFS_RESP_OKAY);
        rd(`PFS_OFS_UPPER, 32'h3302, `PFS_RESP_OKAY);
        rd(`PFS_OFS_LOWER, 32'hFF95, `PFS_RESP_OKAY);
        settle;
        chk(lower_pin_function_select, 16'hFF95);
        chk(pin_oe, 16'h5000);
    endtask : t_reset

    task automatic t_regs;
        wr(`PFS_OFS_DIR, 16'hA5C3, `PFS_RESP_OKAY);
        rd(`PFS_OFS_DIR, 32'hA5C3, `PFS_RESP_OKAY);
        wr(`PFS_OFS_UPPER, 16'h0002, `PFS_RESP_OKAY);
        rd(`PFS_OFS_UPPER, 32'h0002, `PFS_RESP_OKAY);
        wr(`PFS_OFS_LOWER, 16'h1234, `PFS_RESP_OKAY);
        rd(`PFS_OFS_LOWER, 32'h1234, `PFS_RESP_OKAY);
        wr(8'h0C, 16'hFFFF, `PFS_RESP_SLVERR);
        rd(8'h0C, 32'h0, `PFS_RESP_SLVERR);
        rd(`PFS_OFS_DIR, 32'hA5C3, `PFS_RESP_OKAY);
        port_out_data <= 16'h3C5A;
        pin_in <= 16'h9A6B;
        settle;
        chk(pin_oe, 16'hA5C3);
        chk(pin_out & pin_oe, 16'h3C5A & 16'hA5C3);
        chk(port_in_data, 16'h9A6B);
        // Low byte lane only
        s_axi_wstrb <= 4'h1;
        wr(`PFS_OFS_DIR, 16'h00FF, `PFS_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`PFS_OFS_DIR, 32'hA5FF, `PFS_RESP_OKAY);
    endtask : t_regs

    task automatic t_modes;
        drv <= 1'h1;
        port_out_data <= 16'h0000;
        for (int i = 0; i < 5; i++) begin
            wr(`PFS_OFS_DIR, t_dr[i], `PFS_RESP_OKAY);
            wr(`PFS_OFS_UPPER, t_up[i], `PFS_RESP_OKAY);
            pin_in <= 16'h0000;
            settle;
            chk(pin_oe, t_oe[i]);
            chk(pin_out & pin_oe, t_po[i]);
            // Driven levels must follow the peripheral, not sit high
            drv <= 1'h0;
            settle;
            chk(pin_out & t_po[i], 16'h0000);
            drv <= 1'h1;
            // No peripheral input is judged while the capture/compare pins are driven
            if (t_dr[i] == 16'h0000 || t_up[i] != 16'hAAAA) begin
                chk(per, t_lo[i]);
                pin_in <= 16'hFFFF;
                settle;
                chk(per, t_hi[i]);
            end
        end
    endtask : t_modes

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_regs;
        t_modes;
        end_of_test;
    end

    // Whole run needs well under 1000 cycles; allow 4000
    initial begin
        #100000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule : port_a_pin_function_select_test
